//--- iepp_cpu_model.sv
`timescale 1ns/1ps
module iepp_cpu_model
   import iepp_pkg::*;
(
   input  wire logic      clock_i,
   input  wire logic      sys_rst_i,
   input  wire iepp_irq_s irq_i,
   input  wire logic      take_i,
   output logic           irq_ack_o
);
   // one ack pulse per presented request
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         irq_ack_o <= 1'b0;
      else
         irq_ack_o <= take_i & irq_i.req & ~irq_ack_o;
   end
endmodule : iepp_cpu_model

//--- iepp_ctrl.sv
`timescale 1ns/1ps
`include "iepp_regs.svh"
// Function
// RULE_01: main enable: gate bit 7, five sources
// RULE_02: port enable bit k is port line k+2
// RULE_03: main priority bits for five sources
// RULE_04: priority bit 0 low, 1 high
// RULE_05: port priority register at its own address
// RULE_06: polarity bit k for port line k+2
// RULE_07: level held one cycle, served next cycle
// RULE_08: enabled request sets flag, software clears it
// RULE_09: high wins, high nests over low only
// RULE_10: polarity 1 active high, 0 active low
module iepp_ctrl
   import iepp_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [4:0]  main_req_i,
   input  wire logic [7:0]  port_line_pin_i,
   input  wire logic        irq_ack_i,
   input  wire logic        irq_ret_i,
   output iepp_irq_s        irq_o
);
   logic [7:0]  en_main_r;
   logic [7:0]  en_port_r;
   logic [7:0]  pri_main_r;
   logic [7:0]  pri_port_r;
   logic [7:0]  pol_r;
   logic [7:0]  flags_r;
   logic [7:0]  pin_s1_r;
   logic [7:0]  pin_s2_r;
   logic [7:0]  act_prev_r;
   logic [31:0] prdata_r;
   iepp_irq_s   irq_r;
   iepp_nest_e  nest_r;
   iepp_nest_e  nest_nxt;
   logic [7:0]  act_now;
   logic [7:0]  set_w;
   logic [7:0]  idx;
   logic        mapped;
   logic        wr_en;
   logic        flag_wr;
   logic [7:0]  rd_val;
   logic [12:0] en_all;
   logic [12:0] pri_all;
   logic [12:0] pend;
   iepp_pick_s  hi_pick;
   iepp_pick_s  lo_pick;
   iepp_irq_s   irq_nxt;

   // lowest index wins within one level
   function automatic iepp_pick_s pick_first(input logic [12:0] v);
      iepp_pick_s p;
      p = '{valid: 1'b0, idx: 4'h0};
      for (int i = 12; i >= 0; i--) begin
         if (v[i]) begin
            p.valid = 1'b1;
            p.idx   = 4'(i);
         end
      end
      return p;
   endfunction : pick_first

   // apb decode
   assign idx       = paddr_i[9:2];
   assign pready_o  = 1'b1;
   assign prdata_o  = prdata_r;
   assign wr_en     = psel_i & penable_i & pwrite_i & mapped;
   assign flag_wr   = wr_en & (idx == `IEPP_IDX_REQ_FLAGS);
   assign pslverr_o = psel_i & penable_i & ~mapped;

   always_comb begin
      mapped = 1'b1;
      rd_val = 8'h00;
      if (paddr_i[11:10] != 2'b00 || paddr_i[1:0] != 2'b00) begin
         mapped = 1'b0;
      end else begin
         case (idx)
            `IEPP_IDX_ENABLE_MAIN: rd_val = en_main_r;
            `IEPP_IDX_PRIO_MAIN:   rd_val = pri_main_r;
            `IEPP_IDX_PRIO_PORT:   rd_val = pri_port_r; // RULE_05
            `IEPP_IDX_REQ_FLAGS:   rd_val = flags_r;
            `IEPP_IDX_ENABLE_PORT: rd_val = en_port_r;
            `IEPP_IDX_POLARITY:    rd_val = pol_r;
            default:               mapped = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel_i && !penable_i) begin
         prdata_r <= {24'h00_0000, rd_val};
      end
   end

   // control registers
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         en_main_r  <= `IEPP_RST_REG;
         en_port_r  <= `IEPP_RST_REG;
         pri_main_r <= `IEPP_RST_REG;
         pri_port_r <= `IEPP_RST_REG;
         pol_r      <= `IEPP_RST_REG;
      end else if (wr_en) begin
         case (idx)
            `IEPP_IDX_ENABLE_MAIN:
               en_main_r <= pwdata_i[7:0] & `IEPP_MASK_ENABLE_MAIN; // RULE_01
            `IEPP_IDX_PRIO_MAIN:
               pri_main_r <= pwdata_i[7:0] & `IEPP_MASK_PRIO_MAIN; // RULE_03
            `IEPP_IDX_PRIO_PORT:   pri_port_r <= pwdata_i[7:0]; // RULE_05
            `IEPP_IDX_ENABLE_PORT: en_port_r  <= pwdata_i[7:0]; // RULE_02
            `IEPP_IDX_POLARITY:    pol_r      <= pwdata_i[7:0]; // RULE_06
            default: ;
         endcase
      end
   end

   // port line synchroniser
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_s1_r <= `IEPP_RST_REG;
         pin_s2_r <= `IEPP_RST_REG;
      end else begin
         pin_s1_r <= port_line_pin_i;
         pin_s2_r <= pin_s1_r;
      end
   end

   // active level per polarity bit
   assign act_now = ~(pin_s2_r ^ pol_r); // RULE_10
   assign set_w   = act_now & act_prev_r & en_port_r; // RULE_07 RULE_02

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         act_prev_r <= `IEPP_RST_REG;
      end else begin
         act_prev_r <= act_now; // RULE_07
      end
   end

   // sticky flags, hardware set beats software write
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flags_r <= `IEPP_RST_REG;
      end else begin
         flags_r <= (flag_wr ? pwdata_i[7:0] : flags_r) | set_w; // RULE_08
      end
   end

   // request selection
   assign en_all  = {en_port_r, en_main_r[`IEPP_MAIN_SRC_MSB:0]}
                    & {13{en_main_r[`IEPP_GATE_BIT]}}; // RULE_01
   assign pri_all = {pri_port_r, pri_main_r[`IEPP_MAIN_SRC_MSB:0]}; // RULE_04
   assign pend    = {flags_r, main_req_i} & en_all;
   assign hi_pick = pick_first(pend & pri_all);
   assign lo_pick = pick_first(pend & ~pri_all);

   always_comb begin
      irq_nxt = '{req: 1'b0, high: 1'b0, src: `IEPP_RST_SRC};
      if (hi_pick.valid && (nest_r == IEPP_IDLE
                            || nest_r == IEPP_IN_LOW)) begin
         irq_nxt = '{req: 1'b1, high: 1'b1, src: hi_pick.idx}; // RULE_09
      end else if (lo_pick.valid && nest_r == IEPP_IDLE) begin
         irq_nxt = '{req: 1'b1, high: 1'b0, src: lo_pick.idx};
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_r <= '{req: 1'b0, high: 1'b0, src: `IEPP_RST_SRC};
      end else if (irq_ack_i) begin
         irq_r <= '{req: 1'b0, high: 1'b0, src: `IEPP_RST_SRC};
      end else begin
         irq_r <= irq_nxt;
      end
   end
   assign irq_o = irq_r;

   // service nesting
   always_comb begin
      nest_nxt = nest_r;
      if (irq_ack_i && irq_r.req) begin
         case (nest_r)
            IEPP_IDLE:   nest_nxt = irq_r.high ? IEPP_IN_HIGH : IEPP_IN_LOW;
            IEPP_IN_LOW: nest_nxt = irq_r.high ? IEPP_HIGH_LOW : IEPP_IN_LOW;
            default:     nest_nxt = nest_r; // RULE_09
         endcase
      end else if (irq_ret_i) begin
         case (nest_r)
            IEPP_HIGH_LOW: nest_nxt = IEPP_IN_LOW;
            default:       nest_nxt = IEPP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         nest_r <= IEPP_IDLE;
      end else begin
         nest_r <= nest_nxt;
      end
   end

   // checks
   logic [12:0] en_d_r;
   logic [12:0] pri_d_r;
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         en_d_r  <= 13'h0000;
         pri_d_r <= 13'h0000;
      end else begin
         en_d_r  <= en_all;
         pri_d_r <= pri_all;
      end
   end

   property p_gate_blocks;
      @(posedge clock_i) disable iff (sys_rst_i)
      !en_main_r[`IEPP_GATE_BIT] |=> !irq_r.req;
   endproperty
   a_gate_blocks: assert property (p_gate_blocks) // RULE_01
      else $error("request while global gate closed");

   property p_req_enabled;
      @(posedge clock_i) disable iff (sys_rst_i)
      irq_r.req |-> en_d_r[irq_r.src];
   endproperty
   a_req_enabled: assert property (p_req_enabled) // RULE_02
      else $error("request from a disabled source");

   property p_level_matches;
      @(posedge clock_i) disable iff (sys_rst_i)
      irq_r.req |-> irq_r.high == pri_d_r[irq_r.src];
   endproperty
   a_level_matches: assert property (p_level_matches) // RULE_04
      else $error("request level differs from priority bit");

   property p_main_unused_zero;
      @(posedge clock_i) disable iff (sys_rst_i)
      pri_main_r[7:5] == 3'b000 && en_main_r[6:5] == 2'b00;
   endproperty
   a_main_unused_zero: assert property (p_main_unused_zero) // RULE_03
      else $error("unused main bits set");

   property p_flag_sets;
      @(posedge clock_i) disable iff (sys_rst_i)
      set_w != 8'h00 |=> (flags_r & $past(set_w)) == $past(set_w);
   endproperty
   a_flag_sets: assert property (p_flag_sets) // RULE_08
      else $error("held enabled request did not set flag");

   property p_flag_sticky;
      @(posedge clock_i) disable iff (sys_rst_i)
      !flag_wr && set_w == 8'h00 |=> flags_r == $past(flags_r);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) // RULE_08
      else $error("flag changed without request or write");

   property p_new_flag_active;
      @(posedge clock_i) disable iff (sys_rst_i)
      !flag_wr ##1 1'b1 |->
         ((flags_r & ~$past(flags_r)) & ~$past(act_now)) == 8'h00;
   endproperty
   a_new_flag_active: assert property (p_new_flag_active) // RULE_06 RULE_10
      else $error("flag set by inactive port level");

   property p_high_wins;
      @(posedge clock_i) disable iff (sys_rst_i)
      hi_pick.valid && nest_r == IEPP_IDLE && !irq_ack_i
         |=> irq_r.req && irq_r.high;
   endproperty
   a_high_wins: assert property (p_high_wins) // RULE_09
      else $error("high request not chosen");

   property p_no_preempt_high;
      @(posedge clock_i) disable iff (sys_rst_i)
      nest_r == IEPP_IN_HIGH || nest_r == IEPP_HIGH_LOW |=> !irq_r.req;
   endproperty
   a_no_preempt_high: assert property (p_no_preempt_high) // RULE_09
      else $error("high routine preempted");

   c_port_flag: cover property (@(posedge clock_i) set_w != 8'h00);
   c_nested: cover property (@(posedge clock_i) nest_r == IEPP_HIGH_LOW);
   c_low_served: cover property (@(posedge clock_i)
      irq_r.req && !irq_r.high ##1 irq_ack_i);
endmodule : iepp_ctrl

//--- iepp_ctrl_tb.sv
`timescale 1ns/1ps
module iepp_ctrl_tb;
   import iepp_pkg::*;
   logic        clock_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, ack;
   logic        ret = 1'b0;
   logic        take = 1'b0;
   logic [4:0]  mreq = 5'h00;
   logic [7:0]  pins = 8'hFF;
   iepp_irq_s   irq;
   int          n_fail = 0;
   int          n_compared = 0;
   logic [7:0]  ix [6] = '{8'hA8, 8'hB8, 8'hB9, 8'hC0, 8'hE8, 8'hE9};
   logic [7:0]  fx [6] = '{8'h9F, 8'h1F, 8'hFF, 8'h00, 8'hFF, 8'hFF};
   always #5 clock_i = ~clock_i;
   iepp_ctrl iepp_ctrl_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .main_req_i(mreq),
      .port_line_pin_i(pins), .irq_ack_i(ack), .irq_ret_i(ret),
      .irq_o(irq));
   iepp_cpu_model iepp_cpu_model_i (.clock_i(clock_i),
      .sys_rst_i(sys_rst_i), .irq_i(irq), .take_i(take),
      .irq_ack_o(ack));
   task automatic finish_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, a, 2'b00};
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         finish_test();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask : rdc
   task automatic wirq(input logic [5:0] e);
      int k;
      k = 0;
      do begin
         @(negedge clock_i);
         k++;
      end while (irq !== e && k < 12);
      chk("irq", {26'h0, e}, {26'h0, irq});
      if (irq !== e)
         finish_test();
      else
         @(posedge clock_i);
   endtask : wirq
   task automatic take_irq;
      int k;
      @(posedge clock_i);
      take <= 1'b1;
      k = 0;
      do begin
         @(negedge clock_i);
         k++;
      end while (ack !== 1'b1 && k < 12);
      if (ack !== 1'b1) begin
         n_fail++;
         finish_test();
      end else begin
         @(posedge clock_i);
         take <= 1'b0;
      end
   endtask : take_irq
   task automatic ret_irq;
      @(posedge clock_i);
      ret <= 1'b1;
      @(posedge clock_i);
      ret <= 1'b0;
      @(posedge clock_i);
   endtask : ret_irq
   initial begin
      repeat (5) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 6; i++) rdc(ix[i], 32'h0);
      for (int i = 0; i < 6; i++)
         if (i != 3) apb(1'b1, ix[i], 32'hFFFFFFFF);
      for (int i = 0; i < 6; i++)
         if (i != 3) rdc(ix[i], {24'h0, fx[i]});
      apb(1'b0, 8'hA9, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("unmapped", 32'h0, rd);
      wirq(6'h35);
      rdc(8'hC0, 32'hFF);
      pins <= 8'h00;
      repeat (5) @(posedge clock_i);
      apb(1'b1, 8'hC0, 32'h0);
      rdc(8'hC0, 32'h0);
      apb(1'b1, 8'hE8, 32'h01);
      apb(1'b1, 8'hE9, 32'h00);
      wirq(6'h35);
      rdc(8'hC0, 32'h01);
      apb(1'b1, 8'hB9, 32'h00);
      wirq(6'h25);
      mreq <= 5'h08;
      wirq(6'h33);
      take_irq();
      repeat (4) @(negedge clock_i);
      chk("req in high", 32'h0, {31'h0, irq.req});
      @(posedge clock_i);
      mreq <= 5'h00;
      ret_irq();
      wirq(6'h25);
      take_irq();
      mreq <= 5'h08;
      wirq(6'h33);
      take_irq();
      ret_irq();
      ret_irq();
      wirq(6'h33);
      apb(1'b1, 8'hA8, 32'h1F);
      repeat (3) @(negedge clock_i);
      chk("gate off", 32'h0, {31'h0, irq.req});
      apb(1'b1, 8'hE8, 32'h00);
      rdc(8'hC0, 32'h01);
      finish_test();
   end
endmodule : iepp_ctrl_tb

//--- iepp_pkg.sv
package iepp_pkg;
   typedef enum logic [1:0] {
      IEPP_IDLE     = 2'b00,
      IEPP_IN_LOW   = 2'b01,
      IEPP_IN_HIGH  = 2'b10,
      IEPP_HIGH_LOW = 2'b11
   } iepp_nest_e;

   typedef struct packed {
      logic       req;
      logic       high;
      logic [3:0] src;
   } iepp_irq_s;

   typedef struct packed {
      logic       valid;
      logic [3:0] idx;
   } iepp_pick_s;
endpackage : iepp_pkg

//--- iepp_regs.svh
`ifndef IEPP_REGS_SVH
`define IEPP_REGS_SVH
// register indexes, byte address is four times the index
`define IEPP_IDX_ENABLE_MAIN   8'hA8
`define IEPP_IDX_PRIO_MAIN     8'hB8
`define IEPP_IDX_PRIO_PORT     8'hB9
`define IEPP_IDX_REQ_FLAGS     8'hC0
`define IEPP_IDX_ENABLE_PORT   8'hE8
`define IEPP_IDX_POLARITY      8'hE9
// field positions
`define IEPP_GATE_BIT          7
`define IEPP_MAIN_SRC_MSB      4
// used bits of the main registers
`define IEPP_MASK_ENABLE_MAIN  8'h9F
`define IEPP_MASK_PRIO_MAIN    8'h1F
// reset values
`define IEPP_RST_REG           8'h00
`define IEPP_RST_SRC           4'h0
`endif
